/* rtl/hrp_cfg.svh */
// hrp_cfg.svh: constants of the host register port and its global registers.
// assumes it is included once per compilation unit by its bare name.
`ifndef HRP_CFG_SVH
`define HRP_CFG_SVH

// ****************************************************************
// channel count and data width
// ****************************************************************
`define HRP_NCH 6
`define HRP_DW 8

// ****************************************************************
// register offsets
// ****************************************************************
`define HRP_ADDR_TX_ENABLE 8'h00
`define HRP_ADDR_RX_ENABLE 8'h08
`define HRP_ADDR_IRQ_ENABLE 8'h60
`define HRP_ADDR_IRQ_SUMMARY 8'h61
`define HRP_ADDR_PART_CODE 8'h6E
`define HRP_ADDR_REVISION 8'h6F

// ****************************************************************
// reset values
// ****************************************************************
`define HRP_RST_TX_ENABLE 8'h00
`define HRP_RST_RX_ENABLE 8'h00
`define HRP_RST_IRQ_ENABLE 8'h00
`define HRP_RST_IRQ_SUMMARY 8'h00
`define HRP_RST_READ_DATA 8'h00
// idle pin word: strobes and select high, everything else low
`define HRP_PINS_IDLE 21'h070000

// ****************************************************************
// timing
// ****************************************************************
`define HRP_CLK_PERIOD_NS 10
`define HRP_ASYNC_RDY_MAX_NS 65
`define HRP_ASYNC_RDY_MAX_CYC (`HRP_ASYNC_RDY_MAX_NS / `HRP_CLK_PERIOD_NS)
`define HRP_SYNC_RDY_PCLK_PERIODS 2
`define HRP_SYNC_RDY_EXTRA_NS 5
// strobe pin to ready low: two synchroniser stages plus the take edge
`define HRP_PORT_LATENCY_CYC 3

`endif

/* rtl/hrp_pkg.sv */
// hrp_pkg.sv: types shared by the host register port files.
// assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package hrp_pkg;

  // host side pins as sampled, msb first
  typedef struct packed {
    logic pmode;
    logic pclk;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hrp_pins_type;

  typedef enum logic [2:0] {
    HRP_IDLE = 3'b001,
    HRP_DONE = 3'b010,
    HRP_WAIT_CS = 3'b100
  } hrp_state_type;

endpackage : hrp_pkg

`default_nettype wire

/* rtl/hrp_sync.sv */
// hrp_sync.sv: two flip-flop synchroniser for a vector of levels.
// assumes each bit is a level that stays put for several core_clk cycles.
`timescale 1ns/1ps
`default_nettype none

module hrp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // levels
  input wire logic [WIDTH-1:0] d,
  output var logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("hrp_sync: WIDTH must be at least 1");
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : hrp_sync

`default_nettype wire

/* rtl/hrp_top.sv */
// hrp_top.sv: parallel host register port with the global register group.
// assumes host pins are asynchronous to core_clk, channel event and
// status-read pulses come from core_clk logic, and the data wire is
// resolved outside from data_out and data_oe.
`timescale 1ns/1ps
`default_nettype none
`include "hrp_cfg.svh"

// Overview of operation
// - data driven only while select and read strobe are both low.
// - ready goes low after read strobe once read data is valid.
// - write strobe with select low stores the byte, then ready low.
// - same handshake in asynchronous and synchronous timing modes.
// - asynchronous mode ready within 65 ns; strobes held 70 ns.
// - synchronous mode ready within two host clocks plus 5 ns.
// - reset held low 5 us; all registers return to defaults.
// - register 0x60 bits 0..5 enable channel interrupts.
// - read-only 0x61 bit sets on channel event, clears on status read.
// - 0x6E reads a fixed part code; writes ignored.
// - 0x6F reads the silicon revision; writes ignored.
// - interrupt output low on alarm, released once status cleared.
// - timing select pin low asynchronous, high synchronous to pclk.
module hrp_top #(
  parameter int NCH = `HRP_NCH,
  parameter logic [7:0] PART_CODE = 8'hA5, // arbitrary value
  parameter logic [7:0] REVISION = 8'h01 // arbitrary value
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // host port pins
  input wire hrp_pkg::hrp_pins_type host_pins,
  output var logic [7:0] data_out,
  output var logic data_oe,
  output var logic rdy_n,
  output var logic irq_n,
  // channel side
  input wire logic [NCH-1:0] tx_enable_pin,
  input wire logic [NCH-1:0] chan_irq_event,
  input wire logic [NCH-1:0] chan_status_read,
  output var logic [NCH-1:0] tx_channel_on,
  output var logic [NCH-1:0] rx_channel_on
);
  import hrp_pkg::*;

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  generate
    if (NCH < 1 || NCH > `HRP_DW) begin : g_bad_nch
      $error("hrp_top: NCH must be 1 to 8");
    end
    if (`HRP_PORT_LATENCY_CYC > `HRP_ASYNC_RDY_MAX_CYC) begin : g_slow
      $error("hrp_top: port latency exceeds ready bound");
    end
  endgenerate

  // ****************************************************************
  // address decode
  // ****************************************************************
  function automatic logic addr_hit(input logic [7:0] a,
                                    input logic [7:0] reg_addr);
    addr_hit = (a == reg_addr);
  endfunction : addr_hit

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  hrp_pins_type pins_s;
  logic [NCH-1:0] tx_pin_s;

  hrp_sync #(
    .WIDTH($bits(hrp_pins_type)),
    .RST_VAL(`HRP_PINS_IDLE)
  ) u_pin_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .d(host_pins),
    .q(pins_s)
  );

  hrp_sync #(
    .WIDTH(NCH),
    .RST_VAL('0)
  ) u_txpin_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .d(tx_enable_pin),
    .q(tx_pin_s)
  );

  // ****************************************************************
  // strobe qualification
  // ****************************************************************
  hrp_state_type state_q;
  hrp_state_type state_d;
  logic pclk_prev_q;
  logic [NCH-1:0] tx_en_q;
  logic [NCH-1:0] rx_en_q;
  logic [NCH-1:0] irq_en_q;
  logic [NCH-1:0] pend_q;
  logic [NCH-1:0] pend_d;
  logic [7:0] rd_mux;

  wire sel_rd = ~pins_s.cs_n & ~pins_s.rd_n;
  wire sel_wr = ~pins_s.cs_n & ~pins_s.wr_n;
  wire strobes_idle = pins_s.rd_n & pins_s.wr_n;
  wire pclk_rise = pins_s.pclk & ~pclk_prev_q;
  // asynchronous mode takes at once, synchronous on a host clock rise
  wire take_ok = ~pins_s.pmode | pclk_rise;
  wire start = (state_q == HRP_IDLE) & (sel_rd | sel_wr) & take_ok;
  // a read wins if both strobes are low
  wire do_write = start & sel_wr & ~sel_rd;

  wire hit_tx = addr_hit(pins_s.addr, `HRP_ADDR_TX_ENABLE);
  wire hit_rx = addr_hit(pins_s.addr, `HRP_ADDR_RX_ENABLE);
  wire hit_ien = addr_hit(pins_s.addr, `HRP_ADDR_IRQ_ENABLE);
  wire hit_sum = addr_hit(pins_s.addr, `HRP_ADDR_IRQ_SUMMARY);
  wire hit_part = addr_hit(pins_s.addr, `HRP_ADDR_PART_CODE);
  wire hit_rev = addr_hit(pins_s.addr, `HRP_ADDR_REVISION);

  // ****************************************************************
  // read selection
  // ****************************************************************
  always_comb begin
    if (hit_tx) begin
      rd_mux = 8'(tx_en_q);
    end else if (hit_rx) begin
      rd_mux = 8'(rx_en_q);
    end else if (hit_ien) begin
      rd_mux = 8'(irq_en_q);
    end else if (hit_sum) begin
      rd_mux = 8'(pend_q);
    end else if (hit_part) begin
      rd_mux = PART_CODE;
    end else if (hit_rev) begin
      rd_mux = REVISION;
    end else begin
      rd_mux = 8'h00;
    end
  end

  // ****************************************************************
  // handshake state machine
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      HRP_IDLE: begin
        if (start) begin
          state_d = HRP_DONE;
        end
      end
      HRP_DONE: begin
        // ready stays low until the host lets go of the strobe
        if (strobes_idle) begin
          state_d = pins_s.cs_n ? HRP_IDLE : HRP_WAIT_CS;
        end
      end
      HRP_WAIT_CS: begin
        // no new command is taken until select has gone high
        if (pins_s.cs_n) begin
          state_d = HRP_IDLE;
        end
      end
      default: begin
        state_d = HRP_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= HRP_IDLE;
      pclk_prev_q <= 1'b0;
      rdy_n <= 1'b1;
      data_oe <= 1'b0;
      data_out <= `HRP_RST_READ_DATA;
    end else begin
      state_q <= state_d;
      pclk_prev_q <= pins_s.pclk;
      rdy_n <= (state_d != HRP_DONE);
      data_oe <= sel_rd;
      if (start) begin
        data_out <= rd_mux;
      end
    end
  end

  // ****************************************************************
  // global registers
  // ****************************************************************
  // a new channel event wins over a status read in the same cycle
  assign pend_d = (pend_q & ~chan_status_read) | chan_irq_event;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_en_q <= NCH'(`HRP_RST_TX_ENABLE);
      rx_en_q <= NCH'(`HRP_RST_RX_ENABLE);
      irq_en_q <= NCH'(`HRP_RST_IRQ_ENABLE);
      pend_q <= NCH'(`HRP_RST_IRQ_SUMMARY);
    end else begin
      pend_q <= pend_d;
      if (do_write && hit_tx) begin
        tx_en_q <= pins_s.wdata[NCH-1:0];
      end
      if (do_write && hit_rx) begin
        rx_en_q <= pins_s.wdata[NCH-1:0];
      end
      if (do_write && hit_ien) begin
        irq_en_q <= pins_s.wdata[NCH-1:0];
      end
    end
  end

  // ****************************************************************
  // channel controls and interrupt output
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_channel_on <= '0;
      rx_channel_on <= '0;
      irq_n <= 1'b1;
    end else begin
      tx_channel_on <= tx_en_q & tx_pin_s;
      rx_channel_on <= rx_en_q;
      irq_n <= ~|(pend_q & irq_en_q);
    end
  end

endmodule : hrp_top

`default_nettype wire

/* sim/hrp_host_model.sv */
// hrp_host_model.sv: host processor driving the register port pins.
// assumes core_clk is the device clock; pclk runs free at 125 ns.
`timescale 1ns/1ps
`default_nettype none
module hrp_host_model (
  // device side
  input wire logic core_clk,
  input wire logic rdy_n,
  input wire logic data_oe,
  input wire logic [7:0] data_out,
  // host side
  input wire logic sync_mode,
  output var hrp_pkg::hrp_pins_type pins
);
  import hrp_pkg::*;
  logic pclk = 1'b0;
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic drv = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] bus_q = 8'h00;
  always #62.5 pclk = ~pclk;
  // a released wire shows the inverse of the last byte
  assign pins = '{sync_mode, pclk, cs_n, rd_n, wr_n, addr,
    data_oe ? data_out : (drv ? bus_q : ~bus_q)};
  task automatic acc(input logic w, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] q, output logic tmo);
    int n = 0;
    @(posedge core_clk);
    addr <= a;
    cs_n <= 1'b0;
    bus_q <= d;
    drv <= w;
    @(posedge core_clk);
    rd_n <= w;
    wr_n <= !w;
    do begin
      @(posedge core_clk);
      n++;
    end while (rdy_n !== 1'b0 && n < 40);
    q = pins.wdata;
    repeat (7) @(posedge core_clk);
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    drv <= 1'b0;
    while (rdy_n !== 1'b1 && n < 60) begin
      @(posedge core_clk);
      n++;
    end
    cs_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    tmo = n >= 40;
  endtask : acc
endmodule : hrp_host_model
`default_nettype wire

/* sim/hrp_top_chk.sv */
// hrp_top_chk.sv: handshake and output relations of the register port.
// assumes it is bound to hrp_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module hrp_top_chk #(
  parameter int NCH = 6
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // watched ports
  input wire hrp_pkg::hrp_pins_type host_pins,
  input wire logic data_oe,
  input wire logic rdy_n,
  input wire logic irq_n,
  input wire logic [NCH-1:0] tx_enable_pin,
  input wire logic [NCH-1:0] chan_irq_event,
  input wire logic [NCH-1:0] chan_status_read,
  input wire logic [NCH-1:0] tx_channel_on,
  input wire logic [NCH-1:0] rx_channel_on
);
  import hrp_pkg::*;
  wire logic req = !host_pins.cs_n && !(host_pins.rd_n && host_pins.wr_n);
  wire logic quiet = &chan_status_read && chan_irq_event == '0;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  a_rdy_async: assert property (
    $rose(req) && !host_pins.pmode |-> ##[1:6] !rdy_n)
    else $error("ready late in asynchronous mode");
  a_rdy_sync: assert property (
    $rose(req) && host_pins.pmode |-> ##[1:26] !rdy_n)
    else $error("ready late in synchronous mode");
  a_rdy_cause: assert property ($fell(rdy_n) |-> req)
    else $error("ready without a request");
  a_rdy_hold: assert property (!rdy_n && req |=> !rdy_n)
    else $error("ready dropped while strobe held");
  a_oe_select: assert property (data_oe |-> !host_pins.cs_n)
    else $error("data driven while deselected");
  a_oe_read_only: assert property (
    $rose(data_oe) |-> !host_pins.rd_n && !host_pins.cs_n)
    else $error("data driven without read strobe");
  a_tx_gate: assert property (
    (tx_channel_on & ~$past(tx_enable_pin, 3) &
     ~$past(tx_enable_pin, 4)) == '0)
    else $error("transmitter on with enable pin low");
  a_rx_by_write: assert property (
    !$stable(rx_channel_on) |-> !host_pins.wr_n)
    else $error("receiver enables changed without write");
  a_irq_clear: assert property (
    quiet ##1 chan_irq_event == '0 |=> irq_n)
    else $error("interrupt held after status read");
endmodule : hrp_top_chk
bind hrp_top hrp_top_chk #(.NCH(NCH)) u_hrp_top_chk (
  .core_clk(core_clk), .rst_n(rst_n), .host_pins(host_pins),
  .data_oe(data_oe), .rdy_n(rdy_n), .irq_n(irq_n),
  .tx_enable_pin(tx_enable_pin), .chan_irq_event(chan_irq_event),
  .chan_status_read(chan_status_read), .tx_channel_on(tx_channel_on),
  .rx_channel_on(rx_channel_on));
`default_nettype wire

/* sim/hrp_top_tb.sv */
// hrp_top_tb.sv: self-checking bench of the host register port.
// assumes the host model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module hrp_top_tb;
  import hrp_pkg::*;
  localparam logic [7:0] PC = 8'h5C; // arbitrary value
  localparam logic [7:0] REV = 8'h03; // arbitrary value
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic mode = 1'b0;
  logic tmo;
  logic [5:0] txp = '0;
  logic [5:0] ev = '0;
  logic [5:0] srd = '0;
  logic [7:0] dout;
  logic oe;
  logic rdy_n;
  logic irq_n;
  logic [5:0] tx_on;
  logic [5:0] rx_on;
  hrp_pins_type pins;
  int err_total = 0;
  int total_checks = 0;
  always #5 core_clk = ~core_clk;
  hrp_top #(.PART_CODE(PC), .REVISION(REV)) u_hrp_top (
    .core_clk(core_clk), .rst_n(rst_n), .host_pins(pins), .data_out(dout),
    .data_oe(oe), .rdy_n(rdy_n), .irq_n(irq_n), .tx_enable_pin(txp),
    .chan_irq_event(ev), .chan_status_read(srd), .tx_channel_on(tx_on),
    .rx_channel_on(rx_on));
  hrp_host_model u_hrp_host_model (.core_clk(core_clk), .rdy_n(rdy_n),
    .data_oe(oe), .data_out(dout), .sync_mode(mode), .pins(pins));
  task automatic end_sim();
    if (err_total == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // a read compares the byte seen against d
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_hrp_host_model.acc(w, a, d, q, tmo);
    if (tmo) begin
      err_total++;
      $display("Error rdy_n at reg %h expected 0 seen 1", a);
      end_sim();
    end
    if (!w) chk($sformatf("reg %h", a), d, q);
  endtask : acc
  task automatic wrd(input logic [7:0] a, input logic [7:0] d,
      input logic [7:0] e);
    acc(1'b1, a, d);
    acc(1'b0, a, e);
  endtask : wrd
  task automatic pulse(input logic [5:0] e, input logic [5:0] s);
    @(posedge core_clk);
    ev <= e;
    srd <= s;
    @(posedge core_clk);
    ev <= 6'h00;
    srd <= 6'h00;
    repeat (3) @(posedge core_clk);
  endtask : pulse
  task automatic t_defaults();
    acc(1'b0, 8'h00, 8'h00);
    acc(1'b0, 8'h08, 8'h00);
    acc(1'b0, 8'h60, 8'h00);
    acc(1'b0, 8'h61, 8'h00);
    acc(1'b0, 8'h6E, PC);
    acc(1'b0, 8'h6F, REV);
    acc(1'b0, 8'h62, 8'h00);
    chk("rx_on", 8'h00, {2'b00, rx_on});
    chk("tx_on", 8'h00, {2'b00, tx_on});
    chk("irq_n", 8'h01, {7'h00, irq_n});
  endtask : t_defaults
  task automatic t_regs(input logic m);
    @(posedge core_clk);
    mode <= m;
    wrd(8'h00, 8'hFF, 8'h3F);
    wrd(8'h08, 8'h2A, 8'h2A);
    wrd(8'h60, 8'h15, 8'h15);
    wrd(8'h61, 8'h3F, 8'h00);
    wrd(8'h6E, 8'h00, PC);
    wrd(8'h6F, 8'h00, REV);
    chk("rx_on", 8'h2A, {2'b00, rx_on});
  endtask : t_regs
  task automatic t_tx();
    logic [5:0] v [3] = '{6'h00, 6'h3F, 6'h33};
    wrd(8'h00, 8'h15, 8'h15);
    foreach (v[i]) begin
      @(posedge core_clk);
      txp <= v[i];
      repeat (6) @(posedge core_clk);
      chk("tx_on", {2'b00, v[i] & 6'h15}, {2'b00, tx_on});
    end
  endtask : t_tx
  task automatic t_irq();
    pulse(6'h02, 6'h00);
    chk("irq_n", 8'h01, {7'h00, irq_n});
    acc(1'b0, 8'h61, 8'h02);
    pulse(6'h04, 6'h00);
    chk("irq_n", 8'h00, {7'h00, irq_n});
    wrd(8'h60, 8'h00, 8'h00);
    chk("irq_n", 8'h01, {7'h00, irq_n});
    wrd(8'h60, 8'h15, 8'h15);
    acc(1'b0, 8'h61, 8'h06);
    pulse(6'h00, 6'h3F);
    chk("irq_n", 8'h01, {7'h00, irq_n});
    acc(1'b0, 8'h61, 8'h00);
    // event and status read in one cycle: the event must win
    pulse(6'h04, 6'h04);
    chk("irq_n", 8'h00, {7'h00, irq_n});
    acc(1'b0, 8'h61, 8'h04);
    pulse(6'h00, 6'h3F);
    acc(1'b0, 8'h61, 8'h00);
  endtask : t_irq
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    t_defaults();
    t_regs(1'b0);
    t_regs(1'b1);
    t_tx();
    t_irq();
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    t_defaults();
    end_sim();
  end
endmodule : hrp_top_tb
`default_nettype wire
